/* logic/gcc_pkg.sv */
// Shared constants for the gated counter compare unit
package gcc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] OFS_LOAD = 8'h10;
    localparam logic [7:0] OFS_END = 8'h14;
    localparam logic [7:0] OFS_COMPARE = 8'h18;
    localparam logic [7:0] OFS_HYST = 8'h1c;
    localparam logic [7:0] OFS_PULSE = 8'h20;
    localparam logic [7:0] OFS_LATCH = 8'h24;

    // CONFIG fields
    localparam int CFG_PERIODIC = 0;
    localparam int CFG_DIR_LO = 1;
    localparam int CFG_HW_EN = 3;
    localparam int CFG_STOP = 4;
    localparam int CFG_CMP_LO = 5;
    localparam int CFG_WIDTH = 7;

    // CONTROL fields
    localparam int CTL_SOFTWARE_GATE = 0;
    localparam int CTL_OUT_EN = 1;
    localparam int CTL_PLAIN = 2;
    localparam int CTL_WIDTH = 3;

    // STATUS fields
    localparam int STS_GATE = 0;
    localparam int STS_AUTO = 1;
    localparam int STS_OUT_STATE = 2;
    localparam int STS_OUT_STATUS = 3;
    localparam int COMPARATOR_STATUS_FLAG = 4;
    localparam int STS_HYST = 5;
    localparam int STS_PULSE = 6;

    // Reset values
    localparam logic [6:0] CONFIG_RESET = 7'h00;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [31:0] VALUE_RESET = 32'h00000000;
    localparam logic [7:0] HYST_RESET = 8'h00;
    localparam logic [7:0] PULSE_RESET = 8'h00;

    // Limits
    localparam logic [31:0] COUNT_MAX = 32'h7fffffff;
    localparam logic [31:0] COUNT_MIN = 32'h80000000;
    localparam logic [7:0] HYST_MIN_ACTIVE = 8'h02;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_STEP_MS = 2;
    localparam int PULSE_STEP_CYCLES = PULSE_STEP_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DIR_NONE,
        DIR_FORWARD,
        DIR_BACKWARD,
        DIR_SPARE
    } gcc_dir_type;

    typedef enum logic [1:0] {
        CMP_NEVER,
        CMP_GE,
        CMP_LE,
        CMP_PULSE
    } gcc_cmp_type;

endpackage

/* logic/gcc_sync_edge.sv */
// Two-flop synchroniser with rising-edge pulse for external pins
`timescale 1ns/1ps
module gcc_sync_edge (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic pinIn,
    output logic level,
    output logic rise
);
    logic stage1;
    logic levelPrev;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            level <= 1'b0;
            levelPrev <= 1'b0;
        end else begin
            stage1 <= pinIn;
            level <= stage1;
            levelPrev <= level;
        end
    end

    assign rise = level & ~levelPrev;
endmodule // gcc_sync_edge

/* logic/gcc_counter_unit.sv */
// Gated up/down counter with latch, comparator and pulse output on AHB-Lite
// How it works
// - Once forward: past end-1, reload and close
// - Once backward: past end+1, reload and close
// - After auto-close, gate rise restarts from load
// - Periodic none: full range, wrap at limits
// - Periodic forward: past end-1, reload, keep open
// - Periodic backward: past end+1 reload, may overrun
// - Count only while combined internal gate open
// - Hardware gate follows pin level, software gate bit
// - Cancel style restarts, stop style continues
// - No hardware gate: software rise per style
// - Software rise continues; hardware rise per style
// - Auto-closed gate reopens on restricted edges
// - Latch rise captures count while gate open, value kept
// - Four comparator output behaviours selectable
// - No comparison: plain output, flags cleared
// - GE/LE output follows; flag clear needs false
// - Pulse at compare value, main direction only
// - Zero duration: output follows equal condition
// - Duration in 2 ms steps up to 510
// - No retrigger; new duration on next pulse
// - Hysteresis 0..255, below 2 disables it
// - Width change applies on next arrival
// - Result held until hysteresis range left
`timescale 1ns/1ps
module gcc_counter_unit import gcc_pkg::*; #(
    parameter int STEP_CYCLES = PULSE_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic countUpPin,
    input wire logic countDownPin,
    input wire logic hardwareGatePin,
    input wire logic latchPin,
    output logic digitalOut
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pinVec;
    logic [3:0] pinLevel;
    logic [3:0] pinRise;

    assign pinVec = {latchPin, hardwareGatePin, countDownPin, countUpPin};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : gSync
            gcc_sync_edge uSync (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .pinIn(pinVec[gi]),
                .level(pinLevel[gi]),
                .rise(pinRise[gi])
            );
        end
    endgenerate

    logic upRise;
    logic downRise;
    logic hwLevel;
    logic hwRise;
    logic latchRise;
    assign upRise = pinRise[0];
    assign downRise = pinRise[1];
    assign hwLevel = pinLevel[2];
    assign hwRise = pinRise[2];
    assign latchRise = pinRise[3];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [6:0] setup;
    logic [2:0] control;
    logic signed [31:0] count;
    logic signed [31:0] loadValue;
    logic signed [31:0] endValue;
    logic signed [31:0] compareValue;
    logic [7:0] hystSetting;
    logic [7:0] pulseSetting;
    logic signed [31:0] latchedCountValue;
    logic [6:0] status;

    logic wrPending;
    logic [7:0] wrAddr;
    logic addrPhase;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = hsel & htrans[1] & hready;

    function automatic logic [31:0] readMux(input logic [7:0] ofs);
        case (ofs)
            OFS_CONFIG: readMux = {25'h0, setup};
            OFS_CONTROL: readMux = {29'h0, control};
            OFS_STATUS: readMux = {25'h0, status};
            OFS_COUNT: readMux = count;
            OFS_LOAD: readMux = loadValue;
            OFS_END: readMux = endValue;
            OFS_COMPARE: readMux = compareValue;
            OFS_HYST: readMux = {24'h0, hystSetting};
            OFS_PULSE: readMux = {24'h0, pulseSetting};
            OFS_LATCH: readMux = latchedCountValue;
            default: readMux = 32'h00000000;
        endcase
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wrPending <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            wrPending <= addrPhase & hwrite;
            if (addrPhase) begin
                wrAddr <= {haddr[7:2], 2'b00};
            end
            if (addrPhase & ~hwrite) begin
                hrdata <= readMux({haddr[7:2], 2'b00});
            end
        end
    end

    function automatic logic wrHit(input logic [7:0] ofs);
        wrHit = wrPending && (wrAddr == ofs);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            setup <= CONFIG_RESET;
            control <= CONTROL_RESET;
            loadValue <= VALUE_RESET;
            endValue <= VALUE_RESET;
            compareValue <= VALUE_RESET;
            hystSetting <= HYST_RESET;
            pulseSetting <= PULSE_RESET;
        end else begin
            if (wrHit(OFS_CONFIG)) setup <= hwdata[CFG_WIDTH-1:0];
            if (wrHit(OFS_CONTROL)) control <= hwdata[CTL_WIDTH-1:0];
            if (wrHit(OFS_LOAD)) loadValue <= hwdata;
            if (wrHit(OFS_END)) endValue <= hwdata;
            if (wrHit(OFS_COMPARE)) compareValue <= hwdata;
            if (wrHit(OFS_HYST)) hystSetting <= hwdata[7:0];
            if (wrHit(OFS_PULSE)) pulseSetting <= hwdata[7:0];
        end
    end

    logic periodic;
    gcc_dir_type mainDir;
    logic hwEnable;
    logic stopStyle;
    gcc_cmp_type cmpMode;
    logic softwareGateBit;
    logic outEnable;
    logic plainOut;
    assign periodic = setup[CFG_PERIODIC];
    assign mainDir = gcc_dir_type'(setup[CFG_DIR_LO +: 2]);
    assign hwEnable = setup[CFG_HW_EN];
    assign stopStyle = setup[CFG_STOP];
    assign cmpMode = gcc_cmp_type'(setup[CFG_CMP_LO +: 2]);
    assign softwareGateBit = control[CTL_SOFTWARE_GATE];
    assign outEnable = control[CTL_OUT_EN];
    assign plainOut = control[CTL_PLAIN];

    // ------------------------------------------------------------
    // Internal gate
    // ------------------------------------------------------------
    logic swGatePrev;
    logic swRise;
    logic gateOpen;
    logic autoClosed;
    logic hwRiseSeen;
    logic gateLevel;
    logic restartEdge;
    logic reopenAuto;
    logic loadNow;
    logic closeNow;

    assign swRise = softwareGateBit & ~swGatePrev;
    // combine both gates, hardware gate optional
    assign gateLevel = softwareGateBit & (hwEnable ? hwLevel : 1'b1);
    assign restartEdge = hwEnable ? (hwRise & softwareGateBit) : swRise;
    assign reopenAuto = hwEnable ? ((hwRise & softwareGateBit) | (swRise & hwLevel & hwRiseSeen))
                                 : swRise;
    assign loadNow = autoClosed ? reopenAuto : (~stopStyle & restartEdge);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            swGatePrev <= 1'b0;
        end else begin
            swGatePrev <= softwareGateBit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            gateOpen <= 1'b0;
            autoClosed <= 1'b0;
            hwRiseSeen <= 1'b0;
        end else if (closeNow) begin
            gateOpen <= 1'b0;
            autoClosed <= 1'b1;
            hwRiseSeen <= 1'b0;
        end else if (autoClosed) begin
            if (hwRise) hwRiseSeen <= 1'b1;
            if (reopenAuto & gateLevel) begin
                gateOpen <= 1'b1;
                autoClosed <= 1'b0;
            end
        end else begin
            // follow hardware and software gate levels
            gateOpen <= gateLevel;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic stepUp;
    logic stepDown;
    logic signed [31:0] next_count;
    logic lastUp;

    assign stepUp = gateOpen & upRise & ~downRise;
    assign stepDown = gateOpen & downRise & ~upRise;

    always_comb begin
        next_count = count;
        closeNow = 1'b0;
        if (stepUp) begin
            if (mainDir == DIR_FORWARD && count == endValue - 32'sd1) begin
                // reload at end value minus one, close only when counting once
                next_count = loadValue;
                closeNow = ~periodic;
            end else begin
                next_count = count + 32'sd1;
                closeNow = ~periodic && mainDir == DIR_NONE && count == COUNT_MAX;
            end
        end else if (stepDown) begin
            if (mainDir == DIR_BACKWARD && count == endValue + 32'sd1) begin
                // reload at end value plus one
                next_count = loadValue;
                closeNow = ~periodic;
            end else begin
                next_count = count - 32'sd1;
                closeNow = ~periodic && mainDir == DIR_NONE && count == COUNT_MIN;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            count <= VALUE_RESET;
            lastUp <= 1'b1;
        end else begin
            if (wrHit(OFS_COUNT)) begin
                count <= hwdata;
            end else if (loadNow) begin
                count <= loadValue;
            end else begin
                count <= next_count;
            end
            if (stepUp) lastUp <= 1'b1;
            if (stepDown) lastUp <= 1'b0;
        end
    end

    // capture on latch edge while counting
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            latchedCountValue <= VALUE_RESET;
        end else if (latchRise & gateOpen) begin
            latchedCountValue <= count;
        end
    end

    // ------------------------------------------------------------
    // Comparator and hysteresis
    // ------------------------------------------------------------
    logic rawCond;
    logic rawPrev;
    logic eqNow;
    logic eqPrev;
    logic hystActive;
    logic [7:0] hystWidth;
    logic signed [32:0] diff;
    logic [32:0] absDiff;
    logic outsideRange;
    logic cmpResult;
    logic dirOk;
    logic pulseTrigger;

    assign eqNow = (count == compareValue);
    always_comb begin
        case (cmpMode)
            CMP_GE: rawCond = (count >= compareValue);
            CMP_LE: rawCond = (count <= compareValue);
            CMP_PULSE: rawCond = eqNow;
            default: rawCond = 1'b0;
        endcase
    end

    assign diff = {count[31], count} - {compareValue[31], compareValue};
    assign absDiff = diff[32] ? 33'(-diff) : 33'(diff);
    assign outsideRange = absDiff > {25'h0, hystWidth};

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rawPrev <= 1'b0;
            eqPrev <= 1'b0;
        end else begin
            rawPrev <= rawCond;
            eqPrev <= eqNow;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hystActive <= 1'b0;
            hystWidth <= HYST_RESET;
        end else if (cmpMode == CMP_NEVER) begin
            hystActive <= 1'b0;
        end else if (hystActive) begin
            if (outsideRange) hystActive <= 1'b0;
        end else if (rawCond & ~rawPrev & hystSetting >= HYST_MIN_ACTIVE) begin
            hystActive <= 1'b1;
            hystWidth <= hystSetting;
        end
    end

    assign cmpResult = rawCond | hystActive;
    assign dirOk = (mainDir == DIR_NONE) || (mainDir == DIR_FORWARD && lastUp) ||
                   (mainDir == DIR_BACKWARD && !lastUp);
    assign pulseTrigger = cmpMode == CMP_PULSE && eqNow && !eqPrev && dirOk && !hystActive;

    // ------------------------------------------------------------
    // Pulse timer
    // ------------------------------------------------------------
    logic pulseRunning;
    logic [31:0] prescale;
    logic [7:0] stepsLeft;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pulseRunning <= 1'b0;
            prescale <= 32'h00000000;
            stepsLeft <= 8'h00;
        end else if (cmpMode != CMP_PULSE) begin
            pulseRunning <= 1'b0;
        end else if (pulseRunning) begin
            if (prescale == 32'(STEP_CYCLES - 1)) begin
                prescale <= 32'h00000000;
                if (stepsLeft == 8'h01) pulseRunning <= 1'b0;
                stepsLeft <= stepsLeft - 8'h01;
            end else begin
                prescale <= prescale + 32'h00000001;
            end
        end else if (pulseTrigger && pulseSetting != 8'h00) begin
            pulseRunning <= 1'b1;
            prescale <= 32'h00000000;
            stepsLeft <= pulseSetting;
        end
    end

    // ------------------------------------------------------------
    // Output and status
    // ------------------------------------------------------------
    logic compareOut;
    logic comparatorStatusFlag;
    logic cmpClearAllowed;

    always_comb begin
        case (cmpMode)
            CMP_GE, CMP_LE: compareOut = outEnable & cmpResult;
            CMP_PULSE: compareOut = outEnable &
                                    (pulseRunning | (pulseSetting == 8'h00 && eqNow));
            default: compareOut = 1'b0;
        endcase
    end

    assign cmpClearAllowed = (cmpMode == CMP_PULSE) ? !pulseRunning : !cmpResult;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            comparatorStatusFlag <= 1'b0;
        end else if (cmpMode == CMP_NEVER) begin
            comparatorStatusFlag <= 1'b0;
        end else if ((cmpMode == CMP_PULSE) ? pulseTrigger : cmpResult) begin
            comparatorStatusFlag <= 1'b1;
        end else if (wrHit(OFS_STATUS) && hwdata[COMPARATOR_STATUS_FLAG] && cmpClearAllowed) begin
            comparatorStatusFlag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            digitalOut <= 1'b0;
        end else begin
            digitalOut <= (cmpMode == CMP_NEVER) ? plainOut : compareOut;
        end
    end

    assign status = {pulseRunning, hystActive, comparatorStatusFlag,
                     (cmpMode != CMP_NEVER) & digitalOut, digitalOut, autoClosed, gateOpen};

endmodule // gcc_counter_unit

/* tb/gcc_counter_unit_monitor.sv */
// Port-level checker for the gated counter compare unit
`timescale 1ns/1ps
module gcc_counter_unit_monitor import gcc_pkg::*; #(
    parameter int STEP_CYCLES = PULSE_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic digitalOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic rdPend, wrPend;
    logic [7:0] busAddr, pulseLen, hystLen, wLat;
    logic [6:0] cfg;
    logic [2:0] ctl;
    logic [15:0] quiet, hiCnt;
    // ----
    // Mirrors of written settings
    // ----
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdPend <= 1'b0;
            wrPend <= 1'b0;
            busAddr <= 8'h00;
        end else begin
            rdPend <= hsel && htrans[1] && hready && !hwrite;
            wrPend <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) busAddr <= haddr[7:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cfg <= CONFIG_RESET;
            ctl <= CONTROL_RESET;
            pulseLen <= PULSE_RESET;
            hystLen <= HYST_RESET;
            quiet <= 16'h0000;
        end else begin
            quiet <= (quiet == 16'hffff) ? quiet : quiet + 16'h0001;
            if (wrPend && busAddr == OFS_CONFIG) cfg <= hwdata[6:0];
            if (wrPend && busAddr == OFS_CONTROL) ctl <= hwdata[2:0];
            if (wrPend && (busAddr == OFS_CONFIG || busAddr == OFS_CONTROL)) quiet <= 16'h0000;
            if (wrPend && busAddr == OFS_PULSE) pulseLen <= hwdata[7:0];
            if (wrPend && busAddr == OFS_HYST) hystLen <= hwdata[7:0];
        end
    end
    // Width of the pulse in progress is the one set before it began
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hiCnt <= 16'h0000;
            wLat <= 8'h00;
        end else begin
            hiCnt <= digitalOut ? hiCnt + 16'h0001 : 16'h0000;
            if (!digitalOut) wLat <= pulseLen;
        end
    end
    // ----
    // Properties
    // ----
    sequence rd_at(logic [7:0] a);
        rdPend && busAddr == a;
    endsequence
    sequence pulse_end;
        $fell(digitalOut) ##0 (cfg[6:5] == 2'h3 && wLat != 8'h00 && quiet > hiCnt);
    endsequence
    chk_plain_out: assert property (quiet >= 16'h0002 && cfg[6:5] == 2'h0
        |-> digitalOut == ctl[2]) else $error("plain output does not follow control");
    chk_out_gated: assert property (quiet >= 16'h0002 && cfg[6:5] != 2'h0
        && !ctl[1] |-> !digitalOut) else $error("output set while disabled");
    chk_pulse_width: assert property (pulse_end
        |-> hiCnt == wLat * STEP_CYCLES) else $error("pulse length wrong");
    chk_cfg_back: assert property (rd_at(OFS_CONFIG)
        |-> hrdata == {25'h0, $past(cfg)}) else $error("config readback wrong");
    chk_ctl_back: assert property (rd_at(OFS_CONTROL)
        |-> hrdata == {29'h0, $past(ctl)}) else $error("control readback wrong");
    chk_pulse_back: assert property (rd_at(OFS_PULSE)
        |-> hrdata == {24'h0, $past(pulseLen)}) else $error("pulse readback wrong");
    chk_hyst_back: assert property (rd_at(OFS_HYST)
        |-> hrdata == {24'h0, $past(hystLen)}) else $error("hysteresis readback wrong");
    chk_flags_idle: assert property (rd_at(OFS_STATUS) ##0 ($past(cfg[6:5]) == 2'h0)
        |-> hrdata[4:3] == 2'h0) else $error("flags set without comparison");
endmodule // gcc_counter_unit_monitor

bind gcc_counter_unit gcc_counter_unit_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_mon (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .digitalOut(digitalOut));

/* tb/gcc_pin_model.sv */
// Encoder, gate and latch pin model facing the counter unit
`timescale 1ns/1ps
module gcc_pin_model (
    input wire logic ref_clk,
    output logic countUpPin,
    output logic countDownPin,
    output logic hardwareGatePin,
    output logic latchPin
);
    initial begin
        countUpPin = 1'b0;
        countDownPin = 1'b0;
        hardwareGatePin = 1'b0;
        latchPin = 1'b0;
    end
    task automatic pulses(input logic down, input int n, input int gap);
        repeat (n) begin
            if (down) countDownPin <= 1'b1;
            else countUpPin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            countDownPin <= 1'b0;
            countUpPin <= 1'b0;
            repeat (gap) @(posedge ref_clk);
        end
    endtask
    task automatic gate(input logic lvl);
        hardwareGatePin <= lvl;
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic strobe_latch();
        latchPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        latchPin <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule // gcc_pin_model

/* tb/tb.sv */
// Self-checking bench for the gated counter compare unit
`timescale 1ns/1ps
module tb import gcc_pkg::*;;
    typedef struct packed {
        logic [6:0] cfg;
        logic [31:0] load;
        logic [31:0] endv;
        logic [3:0] nDn;
        logic [3:0] nUp;
        logic [31:0] cnt;
        logic [1:0] sts;
    } gcc_row_type;
    logic ref_clk = 1'b0;
    logic resetn, hsel, hwrite;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hrdata;
    logic hready, hresp, countUpPin, countDownPin, hardwareGatePin, latchPin, digitalOut;
    int error_cnt = 0;
    int checks = 0;
    gcc_row_type rows [7] = '{
        '{7'h02, 32'h5, 32'ha, 4'h0, 4'h6, 32'h5, 2'h2},
        '{7'h04, 32'h5, 32'h1, 4'h5, 4'h0, 32'h5, 2'h2},
        '{7'h01, 32'h7ffffffe, 32'h0, 4'h0, 4'h3, 32'h80000001, 2'h1},
        '{7'h01, 32'h80000001, 32'h0, 4'h3, 4'h0, 32'h7ffffffe, 2'h1},
        '{7'h03, 32'h5, 32'h8, 4'h0, 4'h4, 32'h6, 2'h1},
        '{7'h05, 32'h5, 32'h3, 4'h2, 4'h3, 32'h8, 2'h1},
        '{7'h00, 32'h7fffffff, 32'h0, 4'h0, 4'h2, 32'h80000000, 2'h2}};
    gcc_counter_unit #(.STEP_CYCLES(10)) i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .countUpPin(countUpPin), .countDownPin(countDownPin),
        .hardwareGatePin(hardwareGatePin), .latchPin(latchPin), .digitalOut(digitalOut));
    gcc_pin_model i_pins (
        .ref_clk(ref_clk), .countUpPin(countUpPin), .countDownPin(countDownPin),
        .hardwareGatePin(hardwareGatePin), .latchPin(latchPin));
    initial forever #5 ref_clk = ~ref_clk;
    // ----
    // Bus and check tasks
    // ----
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk($sformatf("reg %h", a), q, e);
    endtask
    task automatic final_report();
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        final_report();
    end
    // ----
    // Sequence
    // ----
    initial begin
        resetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= 32'h0;
        hsize <= 3'h0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rc(OFS_CONFIG, 32'h0);
        rc(OFS_COUNT, 32'h0);
        rc(OFS_LATCH, 32'h0);
        foreach (rows[i]) begin
            wr(OFS_CONTROL, 32'h0);
            wr(OFS_CONFIG, {25'h0, rows[i].cfg});
            wr(OFS_LOAD, rows[i].load);
            wr(OFS_END, rows[i].endv);
            wr(OFS_CONTROL, 32'h1);
            i_pins.pulses(1'b1, rows[i].nDn, 3);
            i_pins.pulses(1'b0, rows[i].nUp, 3);
            rc(OFS_COUNT, rows[i].cnt);
            rc(OFS_STATUS, {30'h0, rows[i].sts});
        end
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONFIG, 32'h0a);
        wr(OFS_LOAD, 32'h0);
        wr(OFS_END, 32'h3);
        wr(OFS_CONTROL, 32'h1);
        i_pins.pulses(1'b0, 1, 8);
        rc(OFS_COUNT, 32'h80000000);
        i_pins.gate(1'b1);
        i_pins.pulses(1'b0, 4, 8);
        rc(OFS_STATUS, 32'h2);
        i_pins.gate(1'b0);
        i_pins.gate(1'b1);
        i_pins.pulses(1'b0, 1, 3);
        rc(OFS_COUNT, 32'h1);
        i_pins.gate(1'b0);
        i_pins.pulses(1'b0, 1, 3);
        rc(OFS_COUNT, 32'h1);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONFIG, 32'h09);
        i_pins.gate(1'b1);
        wr(OFS_COUNT, 32'h32);
        wr(OFS_CONTROL, 32'h1);
        i_pins.pulses(1'b0, 1, 3);
        rc(OFS_COUNT, 32'h33);
        wr(OFS_CONFIG, 32'h11);
        wr(OFS_CONTROL, 32'h0);
        i_pins.pulses(1'b0, 1, 3);
        wr(OFS_CONTROL, 32'h1);
        i_pins.pulses(1'b0, 1, 3);
        i_pins.strobe_latch();
        i_pins.pulses(1'b0, 1, 3);
        rc(OFS_COUNT, 32'h35);
        rc(OFS_LATCH, 32'h34);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONFIG, 32'h21);
        wr(OFS_COMPARE, 32'h2);
        wr(OFS_CONTROL, 32'h3);
        i_pins.pulses(1'b0, 2, 3);
        chk("digitalOut", {31'h0, digitalOut}, 32'h1);
        wr(OFS_STATUS, 32'h10);
        rc(OFS_STATUS, 32'h1d);
        i_pins.pulses(1'b1, 1, 3);
        wr(OFS_STATUS, 32'h10);
        rc(OFS_STATUS, 32'h01);
        wr(OFS_CONFIG, 32'h41);
        repeat (3) @(posedge ref_clk);
        chk("digitalOut", {31'h0, digitalOut}, 32'h1);
        wr(OFS_PULSE, 32'h2);
        wr(OFS_CONFIG, 32'h61);
        i_pins.pulses(1'b0, 1, 3);
        wr(OFS_PULSE, 32'h1);
        chk("digitalOut", {31'h0, digitalOut}, 32'h1);
        repeat (25) @(posedge ref_clk);
        chk("digitalOut", {31'h0, digitalOut}, 32'h0);
        wr(OFS_PULSE, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("digitalOut", {31'h0, digitalOut}, 32'h1);
        i_pins.pulses(1'b0, 1, 3);
        chk("digitalOut", {31'h0, digitalOut}, 32'h0);
        wr(OFS_CONFIG, 32'h01);
        wr(OFS_CONTROL, 32'h5);
        rc(OFS_CONTROL, 32'h5);
        chk("digitalOut", {31'h0, digitalOut}, 32'h1);
        rc(OFS_STATUS, 32'h05);
        wr(OFS_HYST, 32'hff);
        rc(OFS_HYST, 32'hff);
        wr(OFS_PULSE, 32'hff);
        rc(OFS_PULSE, 32'hff);
        rc(8'h3c, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        final_report();
    end
endmodule // tb
